// File: paper_jam_detector_tb.sv
// testbench for the paper jam detector with a sheet model.
// assumes a one-cycle supervision tick so every timeout runs quickly.
`timescale 1ns/1ps
`default_nettype none
module paper_jam_detector_tb;
	import pjd_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] v;} pjd_row_type;
	typedef struct {logic m; logic l; logic f; int t; logic [31:0] s;} pjd_fuse_type;
	logic i_clk, i_rst, i_wr, i_rd, i_output_mode_switch, i_vsync, i_print_command;
	logic i_lower_cassette_select, i_manual_feed, i_long_paper, i_pickup_request;
	logic [7:0] i_addr;
	logic [31:0] i_wr_data, o_rd_data, d;
	logic b_reg, b_fus, b_del, feed, m_reg, m_fus, m_del;
	logic o_upper_pickup_solenoid, o_lower_pickup_solenoid, o_print_request, o_irq;
	logic o_jam_indicator, o_main_motor_stop, o_delivery_motor_stop;
	wire i_registration_sensor = b_reg | m_reg;
	wire i_fuser_exit_sensor = b_fus | m_fus;
	wire i_delivery_exit_sensor = b_del | m_del;
	int fails = 0;
	int compares = 0;
	int n;
	pjd_row_type rows [9] = '{'{PJD_CTRL_OFS, 32'h2}, '{PJD_STATUS_OFS, 32'h0},
		'{PJD_MASK_OFS, 32'(PJD_MASK_RST)}, '{PJD_STATE_OFS, 32'h0},
		'{PJD_UP_DLY_OFS, 32'(PJD_UP_DLY_RST)}, '{PJD_UP_STAT_OFS, 32'(PJD_UP_STAT_RST)},
		'{PJD_DN_DLY_OFS, 32'(PJD_DN_DLY_RST)}, '{PJD_DN_STAT_OFS, 32'(PJD_DN_STAT_RST)},
		'{8'h20, 32'h0}};
	pjd_fuse_type fuse [4] = '{'{0, 0, 0, 12900, 32'h6}, '{1, 0, 0, 14100, 32'h6},
		'{0, 1, 1, 14100, 32'h4}, '{1, 0, 1, 14100, 32'h4}};
	pjd_paper_jam_detector #(.TICK_CYCLES(1)) pjd_paper_jam_detector_i (.i_clk, .i_rst,
		.i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_registration_sensor,
		.i_fuser_exit_sensor, .i_delivery_exit_sensor, .i_output_mode_switch, .i_vsync,
		.i_print_command, .i_lower_cassette_select, .i_manual_feed, .i_long_paper,
		.i_pickup_request, .o_upper_pickup_solenoid, .o_lower_pickup_solenoid,
		.o_print_request, .o_jam_indicator, .o_main_motor_stop, .o_delivery_motor_stop, .o_irq);
	pjd_sheet_model pjd_sheet_model_i (.i_clk, .i_feed(feed),
		.i_upper_sol(o_upper_pickup_solenoid), .i_lower_sol(o_lower_pickup_solenoid),
		.i_stop(o_main_motor_stop), .o_reg(m_reg), .o_fuser(m_fus), .o_deliv(m_del));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wr_data <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rd_data;
	endtask
	task automatic lim(input logic [31:0] dl, input logic [31:0] st);
		wr(PJD_UP_DLY_OFS, dl);
		wr(PJD_UP_STAT_OFS, st);
		wr(PJD_DN_DLY_OFS, dl);
		wr(PJD_DN_STAT_OFS, st);
	endtask
	// counts on from n; the caller presets n to cycles already spent
	task automatic wait_jam(input int t);
		while (o_jam_indicator !== 1'b1 && n < t + 100) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		chk("jam time", 32'(n >= t - 1 && n <= t + 6), 32'h1);
	endtask
	task automatic clr;
		{b_reg, b_fus, b_del, i_pickup_request, i_vsync} <= '0;
		i_print_command <= 1'b1;
		wr(PJD_STATUS_OFS, 32'h1f);
		wr(PJD_CTRL_OFS, 32'h3);
		i_print_command <= 1'b0;
		rd(PJD_STATUS_OFS);
		chk("cleared", {d[4:0], o_jam_indicator, o_print_request}, 32'h0);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// the whole run is about 64k cycles; give up at 90k
	initial begin
		#900000;
		fails++;
		conclude();
	end
	initial begin
		{i_wr, i_rd, i_output_mode_switch, i_vsync, i_print_command, i_manual_feed} = '0;
		{i_lower_cassette_select, i_long_paper, i_pickup_request, b_reg, b_fus, b_del} = '0;
		{feed, i_addr, i_wr_data} = '0;
		i_rst = 1'b1;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		foreach (rows[k]) begin
			rd(rows[k].a);
			chk("reset value", d, rows[k].v);
		end
		wr(PJD_MASK_OFS, 32'h1);
		i_pickup_request <= 1'b1;
		#1 chk("upper pickup", {o_lower_pickup_solenoid, o_upper_pickup_solenoid}, 32'h1);
		n = 0;
		wait_jam(PJD_PICKUP_MS);
		chk("stop", {o_main_motor_stop, o_delivery_motor_stop, o_irq}, 32'h7);
		rd(PJD_STATUS_OFS);
		chk("pickup status", d, 32'h1);
		wr(PJD_MASK_OFS, 32'h0);
		#1 chk("irq masked", o_irq, 32'h0);
		clr();
		lim(32'hffff, 32'hffff);
		foreach (fuse[k]) begin
			i_manual_feed <= fuse[k].m;
			i_long_paper <= fuse[k].l;
			i_vsync <= 1'b1;
			n = 0;
			if (fuse[k].f) begin
				repeat (50) @(posedge i_clk);
				b_fus <= 1'b1;
				n = 50;
			end
			wait_jam(fuse[k].t);
			rd(PJD_STATUS_OFS);
			chk("fuser status", d, fuse[k].s);
			chk("print request", o_print_request, 32'h1);
			clr();
		end
		i_manual_feed <= 1'b0;
		lim(32'd30, 32'd60);
		for (int k = 0; k < 4; k++) begin
			i_output_mode_switch <= k[1];
			b_fus <= 1'b1;
			repeat (5) @(posedge i_clk);
			b_fus <= 1'b0;
			if (k[0]) begin
				repeat (5) @(posedge i_clk);
				b_del <= 1'b1;
			end
			// face-up timing began at the leading edge, five cycles back
			n = (k[1] ? 0 : 5) + (k[0] ? 5 : 0);
			wait_jam(k[0] ? 60 : 30);
			rd(PJD_STATUS_OFS);
			chk("delivery status", d, k[0] ? 32'h10 : 32'h8);
			rd(PJD_STATE_OFS);
			chk("mode report", d[1:0], {k[1], 1'b1});
			clr();
		end
		wr(PJD_CTRL_OFS, 32'h0);
		i_vsync <= 1'b1;
		repeat (3) @(posedge i_clk);
		rd(PJD_STATE_OFS);
		chk("disabled armed", 32'(d[PJD_ST_ARMED_LSB +: PJD_NUM_CHECKS]), 32'h0);
		clr();
		lim(32'h100, 32'h100);
		i_lower_cassette_select <= 1'b1;
		feed <= 1'b1;
		i_pickup_request <= 1'b1;
		i_vsync <= 1'b1;
		#1 chk("lower pickup", {o_lower_pickup_solenoid, o_upper_pickup_solenoid}, 32'h2);
		repeat (20) @(posedge i_clk);
		i_print_command <= 1'b1;
		@(posedge i_clk);
		i_print_command <= 1'b0;
		repeat (4500) @(posedge i_clk);
		chk("clean sheet", {o_jam_indicator, o_print_request}, 32'h0);
		conclude();
	end
endmodule
bind pjd_paper_jam_detector pjd_props pjd_props_i (.i_clk, .i_rst, .i_addr, .i_wr_data,
	.i_wr, .i_rd, .o_rd_data, .i_output_mode_switch, .i_vsync, .i_print_command,
	.i_lower_cassette_select, .i_manual_feed, .i_pickup_request, .o_upper_pickup_solenoid,
	.o_lower_pickup_solenoid, .o_print_request, .o_jam_indicator, .o_main_motor_stop,
	.o_delivery_motor_stop);
`default_nettype wire

// File: pjd_paper_jam_detector.sv
// paper path supervision: five timed paper checks, latched jam with motor
// stop, print request window, pickup solenoid steering, register port.
// assumes all sensor and formatter inputs are synchronous to i_clk;
// sensors read 1 while paper blocks them.
//
// Function
// - any failed paper check declares jam, lights indicator, stops main and delivery motors.
// - each check requires arrival or clearing at a sensor before its timeout.
// - pickup jam if registration sensor sees no paper 3.9 s after solenoid.
// - cassette feed: fuser delay jam if no paper at fuser exit 12.9 s after vsync.
// - manual feed: fuser delay jam if no paper at fuser exit 14.1 s after vsync.
// - cassette fuser stationary limit is 14.1 s for long sizes, else 12.9 s.
// - manual feed fuser stationary jam if not cleared 14.1 s after vsync.
// - face-up delivery delay measured from fuser leading edge to delivery arrival.
// - face-down delivery delay measured from fuser trailing edge to delivery arrival.
// - face-up delivery stationary from fuser leading edge to delivery clearing.
// - face-down delivery stationary from fuser trailing edge to delivery clearing.
// - print command within 4 s of vsync rise suppresses print request.
// - formatter picks cassette; only that solenoid drives and starts the pickup check.
// - mode switch selects delivery timing set and is reported to software.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module pjd_paper_jam_detector #(
	parameter int TICK_CYCLES = pjd_pkg::PJD_TICK_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [pjd_pkg::PJD_ADDR_W-1:0] i_addr,
	input wire logic [pjd_pkg::PJD_DATA_W-1:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [pjd_pkg::PJD_DATA_W-1:0] o_rd_data,
	input wire logic i_registration_sensor,
	input wire logic i_fuser_exit_sensor,
	input wire logic i_delivery_exit_sensor,
	input wire logic i_output_mode_switch,
	input wire logic i_vsync,
	input wire logic i_print_command,
	input wire logic i_lower_cassette_select,
	input wire logic i_manual_feed,
	input wire logic i_long_paper,
	input wire logic i_pickup_request,
	output logic o_upper_pickup_solenoid,
	output logic o_lower_pickup_solenoid,
	output logic o_print_request,
	output logic o_jam_indicator,
	output logic o_main_motor_stop,
	output logic o_delivery_motor_stop,
	output logic o_irq
);
	import pjd_pkg::*;

	localparam int N = PJD_NUM_CHECKS;

	logic ctrl_enable;
	logic [N-1:0] status;
	logic [N-1:0] mask;
	logic [PJD_CNT_W-1:0] up_dly;
	logic [PJD_CNT_W-1:0] up_stat;
	logic [PJD_CNT_W-1:0] dn_dly;
	logic [PJD_CNT_W-1:0] dn_stat;
	logic jam;
	logic [31:0] tick_cnt;
	logic tick;
	logic fuser_q;
	logic deliv_q;
	logic vsync_q;
	logic sol_q;
	logic fuser_rise;
	logic fuser_fall;
	logic deliv_rise;
	logic deliv_fall;
	logic vsync_rise;
	logic sol_on;
	logic sol_rise;
	logic face_down;
	logic deliv_start;
	logic clear_req;
	logic [N-1:0] chk_start;
	logic [N-1:0] chk_done;
	logic [N-1:0] chk_armed;
	logic [N-1:0] chk_fail;
	logic [PJD_CNT_W-1:0] chk_limit [N];
	logic [PJD_CNT_W-1:0] fuser_dly_limit;
	logic [PJD_CNT_W-1:0] fuser_stat_limit;
	pjd_preq_state_type preq_state;
	pjd_preq_state_type next_preq_state;
	logic [PJD_CNT_W-1:0] win_cnt;

	// fixed-rate supervision tick
	// one shared divider keeps the timers in step; a check armed mid-period
	// therefore times out between limit-1 and limit ticks after its start
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tick_cnt <= 32'h0;
		end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
			tick_cnt <= 32'h0;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
		end
	end
	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

	// previous levels for edge detection
	// reset levels equal the idle pins (no paper, no sync), so no edge follows reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fuser_q <= 1'b0;
			deliv_q <= 1'b0;
			vsync_q <= 1'b0;
			sol_q <= 1'b0;
		end else begin
			fuser_q <= i_fuser_exit_sensor;
			deliv_q <= i_delivery_exit_sensor;
			vsync_q <= i_vsync;
			sol_q <= sol_on;
		end
	end

	assign fuser_rise = i_fuser_exit_sensor & ~fuser_q;
	assign fuser_fall = ~i_fuser_exit_sensor & fuser_q;
	assign deliv_rise = i_delivery_exit_sensor & ~deliv_q;
	assign deliv_fall = ~i_delivery_exit_sensor & deliv_q;
	assign vsync_rise = i_vsync & ~vsync_q;
	assign face_down = i_output_mode_switch;

	// no pickup while jammed or feeding by hand
	// steering is combinational so a cassette change takes effect at once
	assign sol_on = i_pickup_request & ~jam & ~i_manual_feed;
	assign sol_rise = sol_on & ~sol_q;
	assign o_upper_pickup_solenoid = sol_on & ~i_lower_cassette_select;
	assign o_lower_pickup_solenoid = sol_on & i_lower_cassette_select;

	// fuser limits follow feed source and paper length
	assign fuser_dly_limit = i_manual_feed ? PJD_FUSER_LONG_TICKS : PJD_FUSER_SHORT_TICKS;
	assign fuser_stat_limit = (i_manual_feed | i_long_paper) ?
		PJD_FUSER_LONG_TICKS : PJD_FUSER_SHORT_TICKS;

	// face-up times from leading edge, face-down from trailing edge
	assign deliv_start = face_down ? fuser_fall : fuser_rise;

	// pickup and fuser delay end on a level, so paper already there counts;
	// the stationary and delivery checks need a real edge

	always_comb begin
		chk_start = '0;
		chk_done = '0;
		chk_start[PJD_CHK_PICKUP] = sol_rise;
		chk_done[PJD_CHK_PICKUP] = i_registration_sensor;
		chk_start[PJD_CHK_FUSER_DLY] = vsync_rise;
		chk_done[PJD_CHK_FUSER_DLY] = i_fuser_exit_sensor;
		chk_start[PJD_CHK_FUSER_STAT] = vsync_rise;
		chk_done[PJD_CHK_FUSER_STAT] = fuser_fall;
		chk_start[PJD_CHK_DELIV_DLY] = deliv_start;
		chk_done[PJD_CHK_DELIV_DLY] = deliv_rise;
		chk_start[PJD_CHK_DELIV_STAT] = deliv_start;
		chk_done[PJD_CHK_DELIV_STAT] = deliv_fall;
	end

	assign chk_limit[PJD_CHK_PICKUP] = PJD_PICKUP_TICKS;
	assign chk_limit[PJD_CHK_FUSER_DLY] = fuser_dly_limit;
	assign chk_limit[PJD_CHK_FUSER_STAT] = fuser_stat_limit;
	assign chk_limit[PJD_CHK_DELIV_DLY] = face_down ? dn_dly : up_dly;
	assign chk_limit[PJD_CHK_DELIV_STAT] = face_down ? dn_stat : up_stat;

	// one timer per check; a start restarts it, completion disarms it
	// a jam or a cleared enable drops every timer and refuses new starts
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_chk
			logic [PJD_CNT_W-1:0] cnt;
			logic armed;
			logic fail;
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					cnt <= '0;
					armed <= 1'b0;
					fail <= 1'b0;
				end else begin
					fail <= 1'b0;
					if (jam | ~ctrl_enable) begin
						armed <= 1'b0;
					end else if (chk_start[gi]) begin
						armed <= 1'b1;
						cnt <= '0;
					end else if (armed & chk_done[gi]) begin
						armed <= 1'b0;
					end else if (armed & tick) begin
						if (cnt + 16'h1 >= chk_limit[gi]) begin
							armed <= 1'b0;
							fail <= 1'b1;
						end else begin
							cnt <= cnt + 16'h1;
						end
					end
				end
			end
			assign chk_armed[gi] = armed;
			assign chk_fail[gi] = fail;
		end
	endgenerate

	// clear acts on the write itself and is never stored, so it reads back 0
	assign clear_req = i_wr & (i_addr == PJD_CTRL_OFS) & i_wr_data[PJD_CTRL_CLEAR_BIT];

	// latched jam; a failure in the clearing cycle still wins
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			jam <= 1'b0;
		end else if (|chk_fail) begin
			jam <= 1'b1;
		end else if (clear_req) begin
			jam <= 1'b0;
		end
	end

	assign o_jam_indicator = jam;
	assign o_main_motor_stop = jam;
	assign o_delivery_motor_stop = jam;

	// print request window after vsync rise
	// limitation: a vsync edge inside an open window does not restart it
	always_comb begin
		next_preq_state = preq_state;
		case (preq_state)
			PJD_PR_IDLE: begin
				if (vsync_rise) begin
					next_preq_state = PJD_PR_WINDOW;
				end
			end
			PJD_PR_WINDOW: begin
				if (i_print_command) begin
					next_preq_state = PJD_PR_IDLE;
				end else if (tick & (win_cnt + 16'h1 >= PJD_PRINT_WIN_TICKS)) begin
					next_preq_state = PJD_PR_REQUEST;
				end
			end
			PJD_PR_REQUEST: begin
				if (i_print_command | vsync_rise) begin
					next_preq_state = vsync_rise ? PJD_PR_WINDOW : PJD_PR_IDLE;
				end
			end
			default: begin
				next_preq_state = PJD_PR_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			preq_state <= PJD_PR_IDLE;
			win_cnt <= '0;
		end else begin
			preq_state <= next_preq_state;
			if (next_preq_state == PJD_PR_WINDOW && preq_state != PJD_PR_WINDOW) begin
				win_cnt <= '0;
			end else if (preq_state == PJD_PR_WINDOW && tick) begin
				win_cnt <= win_cnt + 16'h1;
			end
		end
	end
	assign o_print_request = (preq_state == PJD_PR_REQUEST);

	// control and delivery limits
	// pickup and fuser limits are fixed; only delivery timing is programmable
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_enable <= PJD_CTRL_ENABLE_RST;
			mask <= PJD_MASK_RST;
			up_dly <= PJD_UP_DLY_RST;
			up_stat <= PJD_UP_STAT_RST;
			dn_dly <= PJD_DN_DLY_RST;
			dn_stat <= PJD_DN_STAT_RST;
		end else if (i_wr) begin
			if (i_addr == PJD_CTRL_OFS) begin
				ctrl_enable <= i_wr_data[PJD_CTRL_ENABLE_BIT];
			end else if (i_addr == PJD_MASK_OFS) begin
				mask <= i_wr_data[N-1:0];
			end else if (i_addr == PJD_UP_DLY_OFS) begin
				up_dly <= i_wr_data[PJD_CNT_W-1:0];
			end else if (i_addr == PJD_UP_STAT_OFS) begin
				up_stat <= i_wr_data[PJD_CNT_W-1:0];
			end else if (i_addr == PJD_DN_DLY_OFS) begin
				dn_dly <= i_wr_data[PJD_CNT_W-1:0];
			end else if (i_addr == PJD_DN_STAT_OFS) begin
				dn_stat <= i_wr_data[PJD_CNT_W-1:0];
			end
		end
	end

	// sticky jam causes, write one to clear, new event wins
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			status <= '0;
		end else if (i_wr && i_addr == PJD_STATUS_OFS) begin
			status <= (status & ~i_wr_data[N-1:0]) | chk_fail;
		end else begin
			status <= status | chk_fail;
		end
	end

	// level output until software clears or masks every cause
	assign o_irq = |(status & mask);

	// read data stands in the cycle after the strobe only
	// sensor bits are live pin levels, not latched copies
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data <= '0;
		end else if (!i_rd) begin
			o_rd_data <= '0;
		end else if (i_addr == PJD_CTRL_OFS) begin
			o_rd_data <= 32'(ctrl_enable) << PJD_CTRL_ENABLE_BIT;
		end else if (i_addr == PJD_STATUS_OFS) begin
			o_rd_data <= 32'(status);
		end else if (i_addr == PJD_MASK_OFS) begin
			o_rd_data <= 32'(mask);
		end else if (i_addr == PJD_STATE_OFS) begin
			o_rd_data <= (32'(jam) << PJD_ST_JAM_BIT)
				| (32'(face_down) << PJD_ST_FACE_DOWN_BIT)
				| (32'(i_registration_sensor) << PJD_ST_REG_BIT)
				| (32'(i_fuser_exit_sensor) << PJD_ST_FUSER_BIT)
				| (32'(i_delivery_exit_sensor) << PJD_ST_DELIV_BIT)
				| (32'(o_print_request) << PJD_ST_PREQ_BIT)
				| (32'(chk_armed) << PJD_ST_ARMED_LSB);
		end else if (i_addr == PJD_UP_DLY_OFS) begin
			o_rd_data <= 32'(up_dly);
		end else if (i_addr == PJD_UP_STAT_OFS) begin
			o_rd_data <= 32'(up_stat);
		end else if (i_addr == PJD_DN_DLY_OFS) begin
			o_rd_data <= 32'(dn_dly);
		end else if (i_addr == PJD_DN_STAT_OFS) begin
			o_rd_data <= 32'(dn_stat);
		end else begin
			o_rd_data <= '0;
		end
	end

endmodule

`default_nettype wire

// File: pjd_pkg.sv
// constants shared by the paper jam detector: register map, field positions,
// reset values and timeout figures.
// assumes a 100 MHz engine clock and a 1 ms supervision tick.
package pjd_pkg;

	localparam int PJD_ADDR_W = 8;
	localparam int PJD_DATA_W = 32;
	localparam int PJD_NUM_CHECKS = 5;
	localparam int PJD_CNT_W = 16;

	// register byte addresses
	localparam logic [7:0] PJD_CTRL_OFS = 8'h00;
	localparam logic [7:0] PJD_STATUS_OFS = 8'h04;
	localparam logic [7:0] PJD_MASK_OFS = 8'h08;
	localparam logic [7:0] PJD_STATE_OFS = 8'h0c;
	localparam logic [7:0] PJD_UP_DLY_OFS = 8'h10;
	localparam logic [7:0] PJD_UP_STAT_OFS = 8'h14;
	localparam logic [7:0] PJD_DN_DLY_OFS = 8'h18;
	localparam logic [7:0] PJD_DN_STAT_OFS = 8'h1c;

	// control fields
	localparam int PJD_CTRL_CLEAR_BIT = 0;
	localparam int PJD_CTRL_ENABLE_BIT = 1;
	localparam logic PJD_CTRL_ENABLE_RST = 1'b1;

	// check index, also the status and mask bit position
	localparam int PJD_CHK_PICKUP = 0;
	localparam int PJD_CHK_FUSER_DLY = 1;
	localparam int PJD_CHK_FUSER_STAT = 2;
	localparam int PJD_CHK_DELIV_DLY = 3;
	localparam int PJD_CHK_DELIV_STAT = 4;
	localparam logic [4:0] PJD_MASK_RST = 5'h00;

	// state register fields
	localparam int PJD_ST_JAM_BIT = 0;
	localparam int PJD_ST_FACE_DOWN_BIT = 1;
	localparam int PJD_ST_REG_BIT = 2;
	localparam int PJD_ST_FUSER_BIT = 3;
	localparam int PJD_ST_DELIV_BIT = 4;
	localparam int PJD_ST_PREQ_BIT = 5;
	localparam int PJD_ST_ARMED_LSB = 8;

	// supervision tick
	localparam int PJD_CLK_PERIOD_NS = 10;
	localparam int PJD_TICK_NS = 1000000;
	localparam int PJD_TICK_CYCLES = PJD_TICK_NS / PJD_CLK_PERIOD_NS;
	localparam int PJD_TICK_MS = 1;

	// timeouts in milliseconds and in ticks
	localparam int PJD_PICKUP_MS = 3900;
	localparam int PJD_FUSER_SHORT_MS = 12900;
	localparam int PJD_FUSER_LONG_MS = 14100;
	localparam int PJD_PRINT_WIN_MS = 4000;
	localparam logic [15:0] PJD_PICKUP_TICKS = 16'(PJD_PICKUP_MS / PJD_TICK_MS);
	localparam logic [15:0] PJD_FUSER_SHORT_TICKS = 16'(PJD_FUSER_SHORT_MS / PJD_TICK_MS);
	localparam logic [15:0] PJD_FUSER_LONG_TICKS = 16'(PJD_FUSER_LONG_MS / PJD_TICK_MS);
	localparam logic [15:0] PJD_PRINT_WIN_TICKS = 16'(PJD_PRINT_WIN_MS / PJD_TICK_MS);

	// delivery limits after reset, in ticks, software may reprogram
	localparam logic [15:0] PJD_UP_DLY_RST = 16'h0bb8;
	localparam logic [15:0] PJD_UP_STAT_RST = 16'h1770;
	localparam logic [15:0] PJD_DN_DLY_RST = 16'h0bb8;
	localparam logic [15:0] PJD_DN_STAT_RST = 16'h1770;

	typedef enum logic [2:0] {
		PJD_PR_IDLE = 3'b001,
		PJD_PR_WINDOW = 3'b010,
		PJD_PR_REQUEST = 3'b100
	} pjd_preq_state_type;

endpackage

// File: pjd_props.sv
// checker on the detector ports: jam latch, motor stop, solenoid
// steering, print request and state reporting.
// assumes a bind onto the detector top; one clock, reset i_rst.
`timescale 1ns/1ps
`default_nettype none
module pjd_props (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [pjd_pkg::PJD_ADDR_W-1:0] i_addr,
	input wire logic [pjd_pkg::PJD_DATA_W-1:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [pjd_pkg::PJD_DATA_W-1:0] o_rd_data,
	input wire logic i_output_mode_switch,
	input wire logic i_vsync,
	input wire logic i_print_command,
	input wire logic i_lower_cassette_select,
	input wire logic i_manual_feed,
	input wire logic i_pickup_request,
	input wire logic o_upper_pickup_solenoid,
	input wire logic o_lower_pickup_solenoid,
	input wire logic o_print_request,
	input wire logic o_jam_indicator,
	input wire logic o_main_motor_stop,
	input wire logic o_delivery_motor_stop
);
	import pjd_pkg::*;
	logic clr_wr;
	assign clr_wr = i_wr && i_addr == PJD_CTRL_OFS && i_wr_data[PJD_CTRL_CLEAR_BIT];
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence vsync_rise;
		$rose(i_vsync);
	endsequence
	sequence state_read;
		i_rd && i_addr == PJD_STATE_OFS;
	endsequence
	jam_outputs_a: assert property (
		o_main_motor_stop == o_jam_indicator && o_delivery_motor_stop == o_jam_indicator
	) else $error("motor stop differs from jam");
	jam_sol_a: assert property (
		o_jam_indicator |-> !o_upper_pickup_solenoid && !o_lower_pickup_solenoid
	) else $error("solenoid driven during jam");
	jam_hold_a: assert property (
		o_jam_indicator && !clr_wr |=> o_jam_indicator
	) else $error("jam dropped without clear");
	sol_upper_a: assert property (
		o_upper_pickup_solenoid |-> i_pickup_request && !i_lower_cassette_select && !i_manual_feed
	) else $error("upper solenoid wrong");
	sol_lower_a: assert property (
		o_lower_pickup_solenoid |-> i_pickup_request && i_lower_cassette_select && !i_manual_feed
	) else $error("lower solenoid wrong");
	preq_drop_a: assert property (
		o_print_request && i_print_command |=> !o_print_request
	) else $error("print request stayed after command");
	preq_window_a: assert property (
		vsync_rise |=> !o_print_request [*8]
	) else $error("print request inside window");
	mode_report_a: assert property (
		state_read |=> o_rd_data[PJD_ST_FACE_DOWN_BIT] == $past(i_output_mode_switch)
	) else $error("mode not reported");
	jam_report_a: assert property (
		state_read |=> o_rd_data[PJD_ST_JAM_BIT] == $past(o_jam_indicator)
	) else $error("jam state not reported");
endmodule
`default_nettype wire

// File: pjd_sheet_model.sv
// sheet model: one sheet runs past the three paper sensors.
// assumes the bench holds i_feed low between sheets.
`timescale 1ns/1ps
`default_nettype none
module pjd_sheet_model (
	input wire logic i_clk,
	input wire logic i_feed,
	input wire logic i_upper_sol,
	input wire logic i_lower_sol,
	input wire logic i_stop,
	output logic o_reg,
	output logic o_fuser,
	output logic o_deliv
);
	int t;
	always_ff @(posedge i_clk) begin
		if (!i_feed) begin
			t <= -1;
		end else if (t < 0 && (i_upper_sol || i_lower_sol)) begin
			t <= 0;
		end else if (t >= 0 && t < 300 && !i_stop) begin
			t <= t + 1;
		end
	end
	// delivery after the fuser trailing edge so face-down timing holds too
	assign o_reg = t >= 10 && t < 60;
	assign o_fuser = t >= 100 && t < 200;
	assign o_deliv = t >= 210 && t < 260;
endmodule
`default_nettype wire
